/* shared/hips_defs.svh */
// Constants for the hot insert power sequencer
`ifndef HIPS_DEFS_SVH
`define HIPS_DEFS_SVH

`define HIPS_CLK_HZ 100000000
`define HIPS_SEAT_MS 20
`define HIPS_REQ_MS 20
`define HIPS_RISE_MS 200
`define HIPS_FALL_US 32
`define HIPS_OVC_US 20
`define HIPS_SEAT_CYC (`HIPS_SEAT_MS * (`HIPS_CLK_HZ / 1000))
`define HIPS_REQ_CYC (`HIPS_REQ_MS * (`HIPS_CLK_HZ / 1000))
`define HIPS_RISE_CYC (`HIPS_RISE_MS * (`HIPS_CLK_HZ / 1000))
`define HIPS_FALL_CYC (`HIPS_FALL_US * (`HIPS_CLK_HZ / 1000000))
`define HIPS_OVC_CYC (`HIPS_OVC_US * (`HIPS_CLK_HZ / 1000000))

`define HIPS_OFS_CTRL 32'h0000_0000
`define HIPS_OFS_STATUS 32'h0000_0004
`define HIPS_CTRL_RST 1'b0
`define HIPS_CTRL_SOFT_CYCLE 0
`define HIPS_ST_STATE_LSB 0
`define HIPS_ST_GOOD 3
`define HIPS_ST_RESET_N 4
`define HIPS_ST_FAULT 5
`define HIPS_ST_SEATED 6
`define HIPS_ST_INPUTS_OK 7
`define HIPS_RESP_OKAY 2'h0
`define HIPS_RESP_SLVERR 2'h2

`endif

/* shared/hips_pkg.sv */
// Types of the hot insert power sequencer
package hips_pkg;

	typedef enum logic [2:0] {ST_IDLE, ST_ON, ST_DISCH, ST_FAULT, ST_RETRY} hips_state_e;

	typedef enum logic [1:0] {REG_CTRL, REG_STATUS, REG_NONE} hips_reg_e;

	typedef struct packed {
		logic seat_sense_a_n;
		logic seat_sense_b_n;
		logic power_cycle_req_n;
		logic low_rail_input_ok;
		logic high_rail_input_ok;
		logic low_rail_output_good;
		logic low_rail_below_std;
		logic high_rail_below_std;
		logic low_rail_below_alt;
		logic high_rail_below_alt;
		logic overcurrent;
	} hips_sense_s;

	typedef struct packed {
		logic ramp_current_en;
		logic charge_pump_en;
		logic negative_supply_switch_on;
		logic gate_pulldown;
		logic supply_good;
		logic sys_reset_n;
		logic bus_isolate;
		logic fault_n;
	} hips_drive_s;

endpackage

/* rtl/hips_filter.sv */
// Qualification timer: a level held longer than COUNT cycles
`timescale 1ns/10ps
module hips_filter #(
	parameter int unsigned COUNT = 16,
	parameter int unsigned CW = $clog2(COUNT + 1)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic active,
	output logic qual,
	output logic fire
);
	logic [CW-1:0] cnt_r;
	logic qual_r;
	logic fire_r;
	logic qual_nxt;

	assign qual_nxt = active && (cnt_r == COUNT[CW-1:0]);
	assign qual = qual_r;
	assign fire = fire_r;

	// Restarts whenever the level drops, so short pulses never qualify
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
		end else if (!active) begin
			cnt_r <= '0;
		end else if (cnt_r != COUNT[CW-1:0]) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			qual_r <= 1'b0;
			fire_r <= 1'b0;
		end else begin
			qual_r <= qual_nxt;
			fire_r <= qual_nxt && !qual_r;
		end
	end
endmodule // hips_filter

/* rtl/hips_sequencer.sv */
// Hot insert power sequencer with AXI4-Lite control and status
`timescale 1ns/10ps
`include "hips_defs.svh"
module hips_sequencer #(
	parameter int unsigned SEAT_CYC = `HIPS_SEAT_CYC,
	parameter int unsigned REQ_CYC = `HIPS_REQ_CYC,
	parameter int unsigned RISE_CYC = `HIPS_RISE_CYC,
	parameter bit ALT_TRIP = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire hips_pkg::hips_sense_s sense,
	output hips_pkg::hips_drive_s drive
);
	localparam int unsigned FALL_CYC = `HIPS_FALL_CYC;
	localparam int unsigned OVC_CYC = `HIPS_OVC_CYC;

	function automatic hips_pkg::hips_reg_e decode(input logic [31:0] addr);
		if (addr[31:2] == 30'(`HIPS_OFS_CTRL >> 2)) begin
			return hips_pkg::REG_CTRL;
		end else if (addr[31:2] == 30'(`HIPS_OFS_STATUS >> 2)) begin
			return hips_pkg::REG_STATUS;
		end
		return hips_pkg::REG_NONE;
	endfunction

	hips_pkg::hips_state_e state_r;
	hips_pkg::hips_state_e state_nxt;
	hips_pkg::hips_drive_s drive_r;
	hips_pkg::hips_drive_s drive_nxt;
	logic soft_cycle_r;
	logic seated_raw;
	logic inputs_ok;
	logic req_low;
	logic below_trip;
	logic seat_qual;
	logic req_fire;
	logic ovc_fire;
	logic rise_fire;
	logic fall_fire;
	logic aw_held_r;
	logic w_held_r;
	logic [31:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// Seat senses are grounded by the host only when fully inserted
	assign seated_raw = !sense.seat_sense_a_n && !sense.seat_sense_b_n;
	assign inputs_ok = sense.low_rail_input_ok && sense.high_rail_input_ok;
	assign req_low = !sense.power_cycle_req_n || soft_cycle_r;
	// Build option picks which ground sense comparator pair is used
	assign below_trip = ALT_TRIP ? (sense.low_rail_below_alt && sense.high_rail_below_alt) :
		(sense.low_rail_below_std && sense.high_rail_below_std);

	hips_filter #(.COUNT(SEAT_CYC)) u_seat (
		.aclk(aclk),
		.aresetn(aresetn),
		.active(seated_raw),
		.qual(seat_qual),
		.fire()
	);

	// A request shorter than the window never fires
	hips_filter #(.COUNT(REQ_CYC)) u_req (
		.aclk(aclk),
		.aresetn(aresetn),
		.active(req_low),
		.qual(),
		.fire(req_fire)
	);

	hips_filter #(.COUNT(OVC_CYC)) u_ovc (
		.aclk(aclk),
		.aresetn(aresetn),
		.active(sense.overcurrent && state_r == hips_pkg::ST_ON),
		.qual(),
		.fire(ovc_fire)
	);

	hips_filter #(.COUNT(RISE_CYC)) u_rise (
		.aclk(aclk),
		.aresetn(aresetn),
		.active(drive_r.supply_good),
		.qual(),
		.fire(rise_fire)
	);

	hips_filter #(.COUNT(FALL_CYC)) u_fall (
		.aclk(aclk),
		.aresetn(aresetn),
		.active(!drive_r.supply_good),
		.qual(),
		.fire(fall_fire)
	);

	// Sequencing state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			hips_pkg::ST_IDLE: begin
				if (seat_qual && inputs_ok && !req_low) begin
					state_nxt = hips_pkg::ST_ON;
				end
			end
			hips_pkg::ST_ON: begin
				if (!inputs_ok || !seated_raw) begin
					state_nxt = hips_pkg::ST_IDLE;
				end else if (ovc_fire) begin
					state_nxt = hips_pkg::ST_FAULT;
				end else if (req_fire) begin
					state_nxt = hips_pkg::ST_DISCH;
				end
			end
			hips_pkg::ST_DISCH: begin
				// Held while the request is low, then until both rails are down
				if (!req_low && below_trip) begin
					state_nxt = hips_pkg::ST_IDLE;
				end
			end
			hips_pkg::ST_FAULT: begin
				if (!inputs_ok) begin
					state_nxt = hips_pkg::ST_IDLE;
				end else if (req_fire) begin
					// A board pulled out while tripped waits in retry for a fresh seat
					state_nxt = (below_trip && seat_qual) ? hips_pkg::ST_ON :
						hips_pkg::ST_RETRY;
				end
			end
			hips_pkg::ST_RETRY: begin
				if (!inputs_ok) begin
					state_nxt = hips_pkg::ST_IDLE;
				end else if (below_trip && seat_qual) begin
					state_nxt = hips_pkg::ST_ON;
				end
			end
			default: begin
				state_nxt = hips_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= hips_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Supply drive outputs follow the next state
	always_comb begin
		drive_nxt = drive_r;
		drive_nxt.ramp_current_en = (state_nxt == hips_pkg::ST_ON);
		drive_nxt.charge_pump_en = (state_nxt == hips_pkg::ST_ON);
		drive_nxt.negative_supply_switch_on = (state_nxt == hips_pkg::ST_ON);
		drive_nxt.gate_pulldown = (state_nxt != hips_pkg::ST_ON);
		drive_nxt.fault_n = (state_nxt != hips_pkg::ST_FAULT);
		// Comparator passes straight through; only a fault forces it low
		drive_nxt.supply_good = sense.low_rail_output_good &&
			(state_nxt != hips_pkg::ST_FAULT);
		if (rise_fire) begin
			drive_nxt.sys_reset_n = 1'b1;
		end else if (fall_fire) begin
			drive_nxt.sys_reset_n = 1'b0;
		end
		drive_nxt.bus_isolate = !drive_nxt.sys_reset_n;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_r <= '{default: 1'b0, gate_pulldown: 1'b1, bus_isolate: 1'b1,
				fault_n: 1'b1};
		end else begin
			drive_r <= drive_nxt;
		end
	end

	assign drive = drive_r;

	// AXI4-Lite write channels, taken in either order
	assign awready = !aw_held_r && !bvalid_r;
	assign wready = !w_held_r && !bvalid_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r <= 32'h0000_0000;
		end else if (awvalid && awready) begin
			aw_held_r <= 1'b1;
			awaddr_r <= awaddr;
		end else if (aw_held_r && w_held_r) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else if (wvalid && wready) begin
			w_held_r <= 1'b1;
			wdata_r <= wdata;
			wstrb_r <= wstrb;
		end else if (aw_held_r && w_held_r) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `HIPS_RESP_OKAY;
		end else if (aw_held_r && w_held_r) begin
			bvalid_r <= 1'b1;
			bresp_r <= (decode(awaddr_r) == hips_pkg::REG_NONE) ? `HIPS_RESP_SLVERR :
				`HIPS_RESP_OKAY;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Software power-cycle request bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_cycle_r <= `HIPS_CTRL_RST;
		end else if (aw_held_r && w_held_r && wstrb_r[0] &&
			decode(awaddr_r) == hips_pkg::REG_CTRL) begin
			soft_cycle_r <= wdata_r[`HIPS_CTRL_SOFT_CYCLE];
		end
	end

	// AXI4-Lite read channel
	assign arready = !rvalid_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `HIPS_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `HIPS_RESP_OKAY;
			unique case (decode(araddr))
				hips_pkg::REG_CTRL: begin
					rdata_r[`HIPS_CTRL_SOFT_CYCLE] <= soft_cycle_r;
				end
				hips_pkg::REG_STATUS: begin
					rdata_r[`HIPS_ST_STATE_LSB +: 3] <= state_r;
					rdata_r[`HIPS_ST_GOOD] <= drive_r.supply_good;
					rdata_r[`HIPS_ST_RESET_N] <= drive_r.sys_reset_n;
					rdata_r[`HIPS_ST_FAULT] <= !drive_r.fault_n;
					rdata_r[`HIPS_ST_SEATED] <= seat_qual;
					rdata_r[`HIPS_ST_INPUTS_OK] <= inputs_ok;
				end
				hips_pkg::REG_NONE: begin
					rresp_r <= `HIPS_RESP_SLVERR;
				end
			endcase
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_SEATED_BEFORE_ON: assert property (
		$rose(drive_r.charge_pump_en) |-> $past(seat_qual) && seat_qual)
		else $error("Pumps enabled without qualified seat");

	AST_LOCKOUT: assert property (
		$rose(drive_r.charge_pump_en) |-> $past(inputs_ok) && drive_r.ramp_current_en &&
			drive_r.negative_supply_switch_on && !drive_r.gate_pulldown)
		else $error("Power up without input rails or full drive");

	AST_ISOLATE_TRACKS_RESET: assert property (
		drive_r.bus_isolate == !drive_r.sys_reset_n)
		else $error("Bus isolation not opposite to reset");

	AST_RESET_RELEASE: assert property (
		$rose(drive_r.sys_reset_n) |-> $past(drive_r.supply_good, 2) && $past(drive_r.supply_good))
		else $error("Reset released without sustained supply good");

	AST_REQUEST_OFF: assert property (
		state_r == hips_pkg::ST_ON && req_fire && seated_raw && inputs_ok && !ovc_fire
			|=> drive_r.gate_pulldown && !drive_r.negative_supply_switch_on)
		else $error("Qualified request did not pull gates down");

	AST_WAIT_TRIP: assert property (
		state_r == hips_pkg::ST_DISCH && !below_trip |=> !drive_r.charge_pump_en)
		else $error("Power up before outputs below trip level");

	AST_SHORT_REQ_IGNORED: assert property (
		state_r == hips_pkg::ST_ON && !req_fire && !ovc_fire && seated_raw && inputs_ok
			|=> state_r == hips_pkg::ST_ON)
		else $error("On state left without cause");

	AST_RESET_FALL: assert property (
		$fell(drive_r.sys_reset_n) |-> !$past(drive_r.supply_good, 2) && !$past(drive_r.supply_good))
		else $error("Reset asserted without sustained supply loss");

	AST_HOLD_DISCHARGED: assert property (
		state_r == hips_pkg::ST_DISCH && req_low |=> state_r == hips_pkg::ST_DISCH)
		else $error("Discharge left while request low");

	AST_SHORT_OFF: assert property (
		state_r == hips_pkg::ST_ON && ovc_fire && seated_raw && inputs_ok
			|=> !drive_r.charge_pump_en && !drive_r.fault_n && !drive_r.negative_supply_switch_on
			&& !drive_r.supply_good)
		else $error("Short did not shut off and flag fault");

	AST_FAULT_CLEAR: assert property (
		state_r == hips_pkg::ST_FAULT && req_fire && inputs_ok && below_trip && seat_qual
			|=> drive_r.fault_n && drive_r.charge_pump_en && drive_r.negative_supply_switch_on)
		else $error("Fault not cleared by qualified request");

	AST_FAULT_LATCHED: assert property (
		state_r == hips_pkg::ST_FAULT && !req_fire && inputs_ok |=> !drive_r.fault_n)
		else $error("Fault released without request");

	AST_REMOVAL: assert property (
		state_r == hips_pkg::ST_ON && !seated_raw |=> !drive_r.charge_pump_en ##1 !seat_qual)
		else $error("Removal did not power down");

	COV_POWER_UP: cover property ($rose(drive_r.sys_reset_n));
	COV_FAULT: cover property (state_r == hips_pkg::ST_FAULT ##1 state_r != hips_pkg::ST_FAULT);
	COV_CYCLE: cover property (state_r == hips_pkg::ST_DISCH ##1 state_r == hips_pkg::ST_IDLE);
	COV_RETRY: cover property (state_r == hips_pkg::ST_RETRY ##1 state_r == hips_pkg::ST_ON);
endmodule // hips_sequencer

/* bench/hips_rail_model.sv */
// Partner model: backplane sense lines and board rails
`timescale 1ns/10ps
module hips_rail_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic seat_a_n,
	input wire logic seat_b_n,
	input wire logic req_n,
	input wire logic ovc,
	input wire logic in_ok,
	input wire hips_pkg::hips_drive_s drive,
	output hips_pkg::hips_sense_s sense
);
	logic [4:0] lvl_r;
	logic [1:0] div_r;
	// Rails ramp while pumps run and fall while pulled down
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_r <= 5'h0;
			div_r <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
			if (div_r == 2'h0 && drive.charge_pump_en && lvl_r != 5'h10) begin
				lvl_r <= lvl_r + 5'h1;
			end else if (div_r == 2'h0 && drive.gate_pulldown && lvl_r != 5'h0) begin
				lvl_r <= lvl_r - 5'h1;
			end
		end
	end
	// Contacts read low only when grounded by the host
	assign sense = {seat_a_n, seat_b_n, req_n, in_ok, in_ok,
		lvl_r >= 5'hA, lvl_r == 5'h0, lvl_r == 5'h0, lvl_r < 5'h8, lvl_r < 5'h8, ovc};
endmodule // hips_rail_model

/* bench/tb_top.sv */
// Testbench for the hot insert power sequencer
`timescale 1ns/10ps
module tb_top;
	localparam int PUMP = 6;
	localparam int NSS = 5;
	localparam int GOOD = 3;
	localparam int RSTN = 2;
	localparam int FLT = 0;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic [2:0] prot = 3'h0;
	logic seat_a_n = 1'b1, seat_b_n = 1'b1, req_n = 1'b1, ovc = 1'b0, in_ok = 1'b1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	hips_pkg::hips_sense_s sense;
	hips_pkg::hips_drive_s drive;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	int n;
	always #5 aclk = ~aclk;
	hips_sequencer #(.SEAT_CYC(20), .REQ_CYC(20), .RISE_CYC(50)) i_hips_sequencer (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(prot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(prot), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .sense(sense), .drive(drive));
	hips_rail_model i_hips_rail_model (.aclk(aclk), .aresetn(aresetn),
		.seat_a_n(seat_a_n), .seat_b_n(seat_b_n), .req_n(req_n), .ovc(ovc),
		.in_ok(in_ok), .drive(drive), .sense(sense));
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task ticks(input int k);
		repeat (k) @(posedge aclk);
		#1;
	endtask
	task wt(input int s, input logic v, output int c);
		c = 0;
		while (drive[s] !== v && c < 5000) begin
			ticks(1);
			c++;
		end
	endtask
	task axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		logic da, dw;
		da = 1'b0;
		dw = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(da && dw)) begin
			@(negedge aclk);
			da = da | (awvalid & awready);
			dw = dw | (wvalid & wready);
			@(posedge aclk);
			if (da) awvalid <= 1'b0;
			if (dw) wvalid <= 1'b0;
		end
		do begin
			@(negedge aclk);
			r = bresp;
			da = bvalid;
			@(posedge aclk);
		end while (!da);
		bready <= 1'b0;
	endtask
	task axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
		end while (!t);
		arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			t = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end while (!t);
		rready <= 1'b0;
	endtask
	task t_seat;
		chk(drive, 32'h13);
		@(posedge aclk);
		seat_a_n <= 1'b0;
		ticks(40);
		chk(drive[NSS], 1'b0);
		@(posedge aclk);
		seat_b_n <= 1'b0;
		in_ok <= 1'b0;
		ticks(40);
		chk(drive[NSS], 1'b0);
		@(posedge aclk);
		in_ok <= 1'b1;
		wt(NSS, 1'b1, n);
		chk(drive[7:4], 4'hE);
		wt(GOOD, 1'b1, n);
		ticks(40);
		chk(drive[RSTN], 1'b0);
		wt(RSTN, 1'b1, n);
		chk(n < 16 && drive[1] === 1'b0, 1'b1);
		$display("power-up test done");
	endtask
	task t_cycle;
		@(posedge aclk);
		req_n <= 1'b0;
		ticks(10);
		@(posedge aclk);
		req_n <= 1'b1;
		ticks(30);
		chk(drive, 32'hED);
		@(posedge aclk);
		req_n <= 1'b0;
		wt(NSS, 1'b0, n);
		chk(n > 18 && n < 27 && drive.gate_pulldown === 1'b1, 1'b1);
		wt(GOOD, 1'b0, n);
		wt(RSTN, 1'b0, n);
		chk(n > 3190 && n < 3215 && drive[1] === 1'b1, 1'b1);
		ticks(200);
		chk(drive[NSS], 1'b0);
		@(posedge aclk);
		req_n <= 1'b1;
		wt(NSS, 1'b1, n);
		chk(n < 10, 1'b1);
		wt(RSTN, 1'b1, n);
		@(posedge aclk);
		req_n <= 1'b0;
		wt(NSS, 1'b0, n);
		@(posedge aclk);
		req_n <= 1'b1;
		wt(NSS, 1'b1, n);
		chk(n > 40, 1'b1);
		ticks(60);
		chk(drive[RSTN], 1'b1);
		$display("power cycle test done");
	endtask
	task t_fault;
		@(posedge aclk);
		ovc <= 1'b1;
		ticks(1000);
		@(posedge aclk);
		ovc <= 1'b0;
		ticks(2);
		chk(drive[FLT], 1'b1);
		@(posedge aclk);
		ovc <= 1'b1;
		wt(FLT, 1'b0, n);
		chk(n > 1990 && n < 2015, 1'b1);
		chk(drive[7:4], 4'h1);
		ticks(200);
		chk(drive[FLT], 1'b0);
		@(posedge aclk);
		ovc <= 1'b0;
		req_n <= 1'b0;
		wt(FLT, 1'b1, n);
		chk(n < 30 && drive[PUMP] === 1'b1, 1'b1);
		@(posedge aclk);
		req_n <= 1'b1;
		$display("breaker test done");
	endtask
	task t_seatloss;
		@(posedge aclk);
		seat_a_n <= 1'b1;
		ticks(4);
		chk(drive[PUMP], 1'b0);
		@(posedge aclk);
		seat_a_n <= 1'b0;
		ticks(15);
		chk(drive[NSS], 1'b0);
		wt(NSS, 1'b1, n);
		chk(n < 12, 1'b1);
		wt(GOOD, 1'b1, n);
		$display("seat loss test done");
	endtask
	task t_regs;
		axr(32'h4, rd, rs);
		chk({rs, rd[7:0] & 8'hEF}, 10'h0C9);
		axr(32'h0, rd, rs);
		chk({rs, rd}, 34'h0);
		axr(32'h40, rd, rs);
		chk({rs, rd}, 34'h200000000);
		axw(32'h4, 32'hFFFFFFFF, rs);
		chk(rs, 2'h0);
		axw(32'h10, 32'h1, rs);
		chk(rs, 2'h2);
		// Lane 0 disabled: the control bit must not move, protection bits are ignored
		wstrb <= 4'hE;
		prot <= 3'h2;
		axw(32'h0, 32'h1, rs);
		chk(rs, 2'h0);
		axr(32'h0, rd, rs);
		chk({rs, rd}, 34'h0);
		wstrb <= 4'hF;
		prot <= 3'h0;
		axw(32'h0, 32'h1, rs);
		wt(NSS, 1'b0, n);
		chk(n < 30, 1'b1);
		axw(32'h0, 32'h0, rs);
		wt(NSS, 1'b1, n);
		chk(drive[PUMP], 1'b1);
		$display("register test done");
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		ticks(1);
		t_seat();
		t_cycle();
		t_fault();
		t_seatloss();
		t_regs();
		wrap_up();
	end
endmodule // tb_top
